// >>> include/utac_defs.vh
// Constants for the tag air-link coder: timing limits, preambles, widths.
// Assumes a 20 MHz reference clock; included by bare name.
`ifndef UTAC_DEFS_VH
`define UTAC_DEFS_VH

// ****************************************************************
// Clock and forward-link timing
// ****************************************************************
`define UTAC_CLK_PERIOD_NS 50
`define UTAC_TARI_MIN_NS 6250
`define UTAC_TARI_MAX_NS 25000
`define UTAC_TARI_MIN_CYC ((`UTAC_TARI_MIN_NS + `UTAC_CLK_PERIOD_NS - 1) / `UTAC_CLK_PERIOD_NS)
`define UTAC_TARI_MAX_CYC (`UTAC_TARI_MAX_NS / `UTAC_CLK_PERIOD_NS)
`define UTAC_CNT_W 13
`define UTAC_CNT_MAX 13'h1FFF

// ****************************************************************
// Return link
// ****************************************************************
`define UTAC_WORD_W 16
`define UTAC_HALF_W 9
`define UTAC_HALF_MIN 9'h002
`define UTAC_TRCAL_SHIFT 4
`define UTAC_T2_MIN_TPRI 3
`define UTAC_T2_MAX_TPRI 20
`define UTAC_PRE_W 22
`define UTAC_FM0_PRE 6'h29
`define UTAC_MIL_PRE 6'h17
`define UTAC_FM0_PILOT 5'h0C
`define UTAC_MIL_PILOT_SHORT 5'h04
`define UTAC_MIL_PILOT_LONG 5'h10
`define UTAC_FM0_VIOL_LEFT 5'h02
`define UTAC_MODE_FM0 2'h0

`endif

// >>> hw/utac_pie_rx.v
// Forward-link decoder: preamble / frame-sync calibration and PIE bits.
// Assumes rx_env is the demodulated envelope, synchronous to ref_clk, low = pulse.
`timescale 1ns/1ps
`default_nettype none
`include "utac_defs.vh"

module utac_pie_rx (
	input wire ref_clk,
	input wire reset_n,
	input wire rx_env,
	input wire rx_enable,
	output reg rx_bit,
	output reg rx_bit_valid,
	output reg rx_frame_start,
	output reg rx_preamble,
	output reg rx_cmd_end,
	output reg rx_tari_err,
	output reg [`UTAC_CNT_W-1:0] trcal_cnt
);

localparam S_IDLE = 3'h0;
localparam S_DELIM = 3'h1;
localparam S_DATA0 = 3'h2;
localparam S_RTCAL = 3'h3;
localparam S_CAL3 = 3'h4;
localparam S_BITS = 3'h5;

reg [2:0] state;
reg env_q;
reg [`UTAC_CNT_W-1:0] cnt;
reg [`UTAC_CNT_W-1:0] rtcal;
wire fall = env_q & ~rx_env;
wire rise = ~env_q & rx_env;
wire [`UTAC_CNT_W-1:0] pivot = {1'b0, rtcal[`UTAC_CNT_W-1:1]};
wire timeout = cnt > {rtcal[`UTAC_CNT_W-2:0], 1'b0};

// ****************************************************************
// Interval measurement and symbol classification
// ****************************************************************
// Intervals run fall to fall, so RTcal and TRcal are whole symbols; only the
// data-0 after the delimiter is timed from the rise. The pivot is half of RTcal
always @(posedge ref_clk or negedge reset_n) begin
	if (!reset_n) begin
		state <= S_IDLE;
		env_q <= 1'b1;
		cnt <= 13'h0000;
		rtcal <= 13'h0000;
		trcal_cnt <= 13'h0000;
		rx_bit <= 1'b0;
		rx_bit_valid <= 1'b0;
		rx_frame_start <= 1'b0;
		rx_preamble <= 1'b0;
		rx_cmd_end <= 1'b0;
		rx_tari_err <= 1'b0;
	end else begin
		env_q <= rx_env;
		rx_bit_valid <= 1'b0;
		rx_frame_start <= 1'b0;
		rx_cmd_end <= 1'b0;
		rx_tari_err <= 1'b0;
		if (fall || (rise && state == S_DELIM))
			cnt <= 13'h0001;
		else if (cnt != `UTAC_CNT_MAX)
			cnt <= cnt + 13'h0001;
		if (!rx_enable) begin
			state <= S_IDLE;
		end else begin
			case (state)
			S_IDLE: begin
				if (fall)
					state <= S_DELIM;
			end
			S_DELIM: begin
				if (rise)
					state <= S_DATA0;
				else if (cnt == `UTAC_CNT_MAX)
					state <= S_IDLE;
			end
			S_DATA0: begin
				// Data-0 length is Tari, only held to the allowed range; symbols use the RTcal pivot
				if (fall) begin
					if (cnt < `UTAC_TARI_MIN_CYC || cnt > `UTAC_TARI_MAX_CYC) begin
						rx_tari_err <= 1'b1;
						state <= S_IDLE;
					end else begin
						state <= S_RTCAL;
					end
				end else if (cnt == `UTAC_CNT_MAX) begin
					state <= S_IDLE;
				end
			end
			S_RTCAL: begin
				if (fall) begin
					rtcal <= cnt;
					state <= S_CAL3;
				end else if (cnt == `UTAC_CNT_MAX) begin
					state <= S_IDLE;
				end
			end
			S_CAL3: begin
				// Longer than RTcal means TRcal: a full preamble opening a round
				if (fall) begin
					rx_frame_start <= 1'b1;
					state <= S_BITS;
					if (cnt > rtcal) begin
						rx_preamble <= 1'b1;
						trcal_cnt <= cnt;
					end else begin
						rx_preamble <= 1'b0;
						rx_bit <= cnt >= pivot;
						rx_bit_valid <= 1'b1;
					end
				end else if (timeout) begin
					state <= S_IDLE;
				end
			end
			S_BITS: begin
				if (fall) begin
					rx_bit <= cnt >= pivot;
					rx_bit_valid <= 1'b1;
				end else if (env_q && timeout) begin
					rx_cmd_end <= 1'b1;
					state <= S_IDLE;
				end
			end
			default: state <= S_IDLE;
			endcase
		end
	end
end

endmodule // utac_pie_rx
`default_nettype wire

// >>> hw/utac_codec.v
// Air-link coder of a passive UHF tag: PIE receive, FM0 / Miller reply, T2.
// Assumes command logic outside decodes bits and supplies reply words.
//
// What this block does
// - Reply only after a complete interrogator command
// - Reply coded FM0 or Miller as commanded
// - Backscatter output has exactly two states
// - PIE symbols measured against half of RTcal
// - Preamble plus Query starts new round
// - FM0 inverts each boundary but the preamble violation, data-0 mid
// - FM0 preamble chosen by round TRext
// - Miller inverts mid data-1, between zeros
// - Miller preamble chosen by round TRext
// - Words sent MSB first, 16 bits
`timescale 1ns/1ps
`default_nettype none
`include "utac_defs.vh"

module utac_codec (
	input wire ref_clk,
	input wire reset_n,
	input wire rx_env,
	input wire round_load,
	input wire round_trext,
	input wire [1:0] round_mode,
	input wire tx_start,
	input wire tx_word_valid,
	input wire [`UTAC_WORD_W-1:0] tx_word,
	output wire rx_bit,
	output wire rx_bit_valid,
	output wire rx_frame_start,
	output wire rx_preamble,
	output wire rx_cmd_end,
	output wire rx_tari_err,
	output reg tx_word_take,
	output reg tx_busy,
	output reg bs_state,
	output reg t2_window
);

localparam P_IDLE = 3'h0;
localparam P_PRE = 3'h1;
localparam P_DATA = 3'h2;
localparam P_END = 3'h3;
localparam P_T2 = 3'h4;

reg [2:0] phase;
reg armed;
reg trext;
reg [1:0] mode;
reg [`UTAC_HALF_W-1:0] half_per;
reg [`UTAC_HALF_W-1:0] hcnt;
reg [4:0] sym_half;
reg [`UTAC_PRE_W-1:0] pre_sh;
reg [4:0] pre_left;
reg [`UTAC_WORD_W-1:0] word_sh;
reg [4:0] word_left;
reg cur_bit;
reg base;
reg sub;
reg [5:0] t2_cnt;
wire [`UTAC_CNT_W-1:0] trcal_cnt;
wire rx_enable = !tx_busy;

utac_pie_rx u_rx (
	.ref_clk(ref_clk),
	.reset_n(reset_n),
	.rx_env(rx_env),
	.rx_enable(rx_enable),
	.rx_bit(rx_bit),
	.rx_bit_valid(rx_bit_valid),
	.rx_frame_start(rx_frame_start),
	.rx_preamble(rx_preamble),
	.rx_cmd_end(rx_cmd_end),
	.rx_tari_err(rx_tari_err),
	.trcal_cnt(trcal_cnt)
);

// ****************************************************************
// Symbol timing and encoder next state
// ****************************************************************
// Half-periods per symbol: 2 for FM0, 2M for Miller
wire miller = mode != `UTAC_MODE_FM0;
wire [4:0] halves = miller ? (5'h02 << mode) : 5'h02;
wire half_en = (hcnt == 9'h000) && (phase == P_PRE || phase == P_DATA || phase == P_END
	|| phase == P_T2);
wire boundary = sym_half == 5'h00;
wire mid = sym_half == {1'b0, halves[4:1]};
wire sending = phase == P_PRE || phase == P_DATA;
wire need_word = phase == P_DATA && word_left == 5'h00;
wire take_word = boundary && need_word && tx_word_valid;
wire fm0_viol = !miller && phase == P_PRE && pre_left == `UTAC_FM0_VIOL_LEFT;
wire [`UTAC_CNT_W-1:0] trcal_half = trcal_cnt >> `UTAC_TRCAL_SHIFT;
reg nb;
reg next_base;
reg next_sub;

// Choose the next symbol and apply the inversions of the selected code
always @* begin
	nb = 1'b1;
	if (phase == P_PRE)
		nb = pre_sh[`UTAC_PRE_W-1];
	else if (take_word)
		nb = tx_word[`UTAC_WORD_W-1];
	else if (phase == P_DATA && !need_word)
		nb = word_sh[`UTAC_WORD_W-1];
	next_base = base;
	next_sub = miller ? ~sub : 1'b0;
	if (boundary && phase != P_T2) begin
		if (!miller)
			next_base = fm0_viol ? base : ~base;
		else if (!cur_bit && !nb)
			next_base = ~base;
	end else if (mid && phase != P_T2) begin
		if (!miller && !cur_bit)
			next_base = ~base;
		else if (miller && cur_bit)
			next_base = ~base;
	end
end

// ****************************************************************
// Round settings and reply permission
// ****************************************************************
// Query settings hold for the round; permission needs a finished command
always @(posedge ref_clk or negedge reset_n) begin
	if (!reset_n) begin
		trext <= 1'b0;
		mode <= `UTAC_MODE_FM0;
		armed <= 1'b0;
	end else begin
		if (round_load && rx_preamble) begin
			trext <= round_trext;
			mode <= round_mode;
		end
		if (rx_cmd_end)
			armed <= 1'b1;
		else if (rx_frame_start || (tx_start && phase == P_IDLE))
			armed <= 1'b0;
	end
end

// ****************************************************************
// Reply sequencer
// ****************************************************************
// Preamble, MSB-first words, dummy 1, then the T2 turnaround window
always @(posedge ref_clk or negedge reset_n) begin
	if (!reset_n) begin
		phase <= P_IDLE;
		half_per <= `UTAC_HALF_MIN;
		hcnt <= 9'h000;
		sym_half <= 5'h00;
		pre_sh <= 22'h000000;
		pre_left <= 5'h00;
		word_sh <= 16'h0000;
		word_left <= 5'h00;
		cur_bit <= 1'b1;
		base <= 1'b0;
		sub <= 1'b0;
		t2_cnt <= 6'h00;
		tx_word_take <= 1'b0;
		tx_busy <= 1'b0;
		bs_state <= 1'b0;
		t2_window <= 1'b0;
	end else begin
		tx_word_take <= 1'b0;
		if (phase != P_IDLE)
			hcnt <= half_en ? half_per - 9'h001 : hcnt - 9'h001;
		case (phase)
		P_IDLE, P_T2: begin
			if (tx_start && armed && phase == P_IDLE) begin
				// Link period latched once and held for the whole reply
				if (trcal_half[`UTAC_CNT_W-1:`UTAC_HALF_W] != 4'h0)
					half_per <= 9'h1FF;
				else if (trcal_half[`UTAC_HALF_W-1:0] < `UTAC_HALF_MIN)
					half_per <= `UTAC_HALF_MIN;
				else
					half_per <= trcal_half[`UTAC_HALF_W-1:0];
				hcnt <= 9'h000;
				sym_half <= 5'h00;
				cur_bit <= 1'b1;
				base <= 1'b0;
				sub <= 1'b0;
				word_left <= 5'h00;
				tx_busy <= 1'b1;
				phase <= P_PRE;
				if (mode == `UTAC_MODE_FM0) begin
					pre_sh <= {`UTAC_FM0_PRE, 16'h0000};
					pre_left <= trext ? 5'h06 + `UTAC_FM0_PILOT : 5'h06;
				end else begin
					pre_sh <= {`UTAC_MIL_PRE, 16'h0000};
					pre_left <= trext ? 5'h06 + `UTAC_MIL_PILOT_LONG
						: 5'h06 + `UTAC_MIL_PILOT_SHORT;
					if (trext)
						pre_sh <= {`UTAC_MIL_PRE, 16'h0000} >> `UTAC_MIL_PILOT_LONG;
					else
						pre_sh <= {`UTAC_MIL_PRE, 16'h0000} >> `UTAC_MIL_PILOT_SHORT;
				end
				if (mode == `UTAC_MODE_FM0 && trext)
					pre_sh <= {`UTAC_FM0_PRE, 16'h0000} >> `UTAC_FM0_PILOT;
			end else if (phase == P_T2) begin
				// Window counts half-periods: open from 3 to 20 Tpri
				if (rx_frame_start || t2_cnt == 2 * `UTAC_T2_MAX_TPRI) begin
					phase <= P_IDLE;
					t2_window <= 1'b0;
				end else if (half_en) begin
					t2_cnt <= t2_cnt + 6'h01;
					t2_window <= t2_cnt + 6'h01 >= 2 * `UTAC_T2_MIN_TPRI;
				end
			end
		end
		P_PRE, P_DATA, P_END: begin
			if (half_en) begin
				base <= next_base;
				sub <= next_sub;
				bs_state <= next_base ^ (miller & next_sub);
				sym_half <= (sym_half == halves - 5'h01) ? 5'h00 : sym_half + 5'h01;
				if (boundary) begin
					cur_bit <= nb;
					if (phase == P_END) begin
						// Dummy 1 done: stop modulating and open the turnaround
						phase <= P_T2;
						bs_state <= 1'b0;
						tx_busy <= 1'b0;
						t2_cnt <= 6'h00;
					end else if (phase == P_PRE) begin
						pre_sh <= {pre_sh[`UTAC_PRE_W-2:0], 1'b0};
						pre_left <= pre_left - 5'h01;
						if (pre_left == 5'h01)
							phase <= P_DATA;
					end else if (take_word) begin
						word_sh <= {tx_word[`UTAC_WORD_W-2:0], 1'b0};
						word_left <= 5'h0F;
						tx_word_take <= 1'b1;
					end else if (need_word) begin
						phase <= P_END;
					end else begin
						word_sh <= {word_sh[`UTAC_WORD_W-2:0], 1'b0};
						word_left <= word_left - 5'h01;
					end
				end
			end
		end
		default: phase <= P_IDLE;
		endcase
		if (!sending && phase != P_END)
			bs_state <= 1'b0;
	end
end

endmodule // utac_codec
`default_nettype wire

// >>> tb/utac_sva.sv
// Checker for the tag air-link coder, bound to its top module.
// Assumes one clock domain with an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module utac_sva (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic tx_start,
	input wire logic tx_busy,
	input wire logic bs_state,
	input wire logic tx_word_take,
	input wire logic rx_bit_valid,
	input wire logic rx_frame_start,
	input wire logic rx_tari_err,
	input wire logic t2_window
);
	// ********
	// Properties
	// ********
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	chk_no_self_start: assert property ($rose(bs_state) |-> tx_busy)
		else $error("reflection changed outside a reply");
	chk_busy_cause: assert property ($rose(tx_busy) |-> $past(tx_start))
		else $error("reply began without a request");
	chk_idle_low: assert property (!tx_busy && !$past(tx_busy) |-> !bs_state)
		else $error("reflection left on while idle");
	chk_half_min: assert property ($changed(bs_state) |=> $stable(bs_state))
		else $error("half period shorter than two cycles");
	chk_take_once: assert property (tx_word_take |=> !tx_word_take)
		else $error("word take longer than one cycle");
	chk_take_busy: assert property (tx_word_take |-> tx_busy)
		else $error("word taken outside a reply");
	chk_rx_hold: assert property (tx_busy |-> !rx_bit_valid && !rx_frame_start)
		else $error("decoder active during a reply");
	chk_err_drop: assert property (rx_tari_err |-> !rx_frame_start && !rx_bit_valid)
		else $error("sync kept after a bad reference interval");
	chk_t2_early: assert property ($fell(tx_busy) |-> !t2_window [*8])
		else $error("turnaround window opened too early");
	chk_t2_opens: assert property ($fell(tx_busy) |-> ##[12:1000] t2_window)
		else $error("turnaround window never opened");
	cov_reply: cover property ($rose(tx_busy));
	cov_err: cover property (rx_tari_err);
	cov_t2: cover property ($rose(t2_window));
endmodule // utac_sva
bind utac_codec utac_sva i_sva (.ref_clk(ref_clk), .reset_n(reset_n), .tx_start(tx_start),
	.tx_busy(tx_busy), .bs_state(bs_state), .tx_word_take(tx_word_take),
	.rx_bit_valid(rx_bit_valid), .rx_frame_start(rx_frame_start),
	.rx_tari_err(rx_tari_err), .t2_window(t2_window));
`default_nettype wire

// >>> tb/utac_reader_model.sv
// Interrogator model: drives the forward envelope in pulse-interval code.
// Assumes the tag clock; the bench calls its frame task.
`timescale 1ns/1ps
`default_nettype none
module utac_reader_model (
	input wire logic ref_clk,
	output logic rx_env
);
	// ********
	// Envelope
	// ********
	// Plain carrier between frames and while listening
	initial begin
		rx_env = 1'h1;
	end
	// High for len-pw cycles, then a low pulse of pw cycles
	task automatic sym(input int len, input int pw);
		repeat (len - pw) @(posedge ref_clk);
		rx_env <= 1'h0;
		repeat (pw) @(posedge ref_clk);
		rx_env <= 1'h1;
	endtask
	// Gap, delimiter, data-0, RTcal, TRcal if a preamble, bits MSB first
	task automatic frame(input int t2, input int tari, input bit pre, input logic [15:0] bits,
		input int nb);
		int pw;
		int rt;
		pw = tari / 2;
		rt = 3 * tari;
		repeat (t2) @(posedge ref_clk);
		rx_env <= 1'h0;
		repeat (250) @(posedge ref_clk);
		rx_env <= 1'h1;
		sym(tari + pw, pw);
		sym(rt, pw);
		if (pre) begin
			sym(rt + 8, pw);
		end
		for (int i = nb - 1; i >= 0; i--) begin
			sym(bits[i] ? 2 * tari : tari, pw);
		end
		repeat (2 * rt + 20) @(posedge ref_clk);
	endtask
endmodule // utac_reader_model
`default_nettype wire

// >>> tb/test_uhf_tag_air_link_codec.sv
// Self-checking bench for the tag air-link coder with an interrogator model.
// Assumes the design header on the include path and a 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "utac_defs.vh"
module test_uhf_tag_air_link_codec;
	logic ref_clk, reset_n, round_load, round_trext, tx_start, tx_word_valid;
	logic [1:0] round_mode;
	logic [`UTAC_WORD_W-1:0] tx_word;
	logic [15:0] got;
	wire logic rx_env, rx_bit, rx_bit_valid, rx_frame_start, rx_preamble, rx_cmd_end;
	wire logic rx_tari_err, tx_word_take, tx_busy, bs_state, t2_window;
	int fail_count = 0;
	int check_count = 0;
	int ends = 0;
	int errs = 0;
	int h;
	utac_reader_model i_reader (.ref_clk(ref_clk), .rx_env(rx_env));
	utac_codec i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .rx_env(rx_env),
		.round_load(round_load), .round_trext(round_trext), .round_mode(round_mode),
		.tx_start(tx_start), .tx_word_valid(tx_word_valid), .tx_word(tx_word),
		.rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .rx_frame_start(rx_frame_start),
		.rx_preamble(rx_preamble), .rx_cmd_end(rx_cmd_end), .rx_tari_err(rx_tari_err),
		.tx_word_take(tx_word_take), .tx_busy(tx_busy), .bs_state(bs_state),
		.t2_window(t2_window));
	// ********
	// Clock, monitors, helpers
	// ********
	// 50 ns clock
	initial begin
		ref_clk = 1'h0;
		forever #25 ref_clk = ~ref_clk;
	end
	// Gather decoded bits, count pulses, drop word valid once taken
	always @(posedge ref_clk) begin
		if (rx_bit_valid === 1'h1) got <= {got[14:0], rx_bit};
		ends <= ends + int'(rx_cmd_end === 1'h1);
		errs <= errs + int'(rx_tari_err === 1'h1);
		if (tx_word_take === 1'h1) tx_word_valid <= 1'h0;
	end
	task automatic check(input logic ok, input string msg);
		check_count++;
		if (ok !== 1'h1) begin
			fail_count++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask
	task automatic complete_run;
		if (fail_count == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Expected FM0 half-symbol levels, first half in bit 0
	function automatic logic [69:0] fm0_exp(input logic x, input logic [15:0] w);
		logic [34:0] s;
		logic [69:0] e;
		logic l;
		int k;
		s = {12'h000, `UTAC_FM0_PRE, w, 1'h1};
		l = 1'h0;
		k = 0;
		e = 70'h0;
		for (int j = x ? 0 : 12; j < 35; j++) begin
			if (j != 16) l = ~l;
			e[k] = l;
			if (s[34 - j] == 1'h0) l = ~l;
			e[k + 1] = l;
			k += 2;
		end
		return e;
	endfunction
	// Expected Miller levels per half period, m subcarrier cycles per symbol
	function automatic logic [639:0] mil_exp(input logic x, input int m, input logic [15:0] w);
		logic [38:0] s;
		logic [639:0] e;
		logic b;
		logic p;
		logic c;
		int k;
		s = {16'h0000, `UTAC_MIL_PRE, w, 1'h1};
		b = 1'h0;
		p = 1'h1;
		c = 1'h0;
		k = 0;
		e = '0;
		for (int j = x ? 0 : 12; j < 39; j++) begin
			for (int i = 0; i < 2 * m; i++) begin
				if (i == 0 && !p && !s[38 - j]) b = ~b;
				if (i == m && s[38 - j]) b = ~b;
				c = ~c;
				e[k] = b ^ c;
				k++;
			end
			p = s[38 - j];
		end
		return e;
	endfunction
	// A request with no command pending must be ignored
	task automatic idle_start;
		tx_start <= 1'h1;
		@(posedge ref_clk);
		tx_start <= 1'h0;
		repeat (3) @(posedge ref_clk);
		check(tx_busy === 1'h0, "reply without command");
	endtask
	// Request a reply, sample each half period, then the turnaround
	task automatic reply(input logic x, input logic [1:0] m);
		logic [69:0] e;
		logic [639:0] g;
		int n;
		int k;
		e = fm0_exp(x, tx_word);
		g = mil_exp(x, 1 << m, tx_word);
		n = 2 * (1 << m) * ((m == `UTAC_MODE_FM0) ? (x ? 35 : 23) : (x ? 39 : 27));
		tx_word_valid <= 1'h1;
		tx_start <= 1'h1;
		@(posedge ref_clk);
		tx_start <= 1'h0;
		@(posedge ref_clk);
		#1 check(tx_busy === 1'h1, "reply not started");
		repeat (h / 2 + 1) @(posedge ref_clk);
		k = 0;
		while (tx_busy === 1'h1 && k < 1200) begin
			if (m == `UTAC_MODE_FM0 && k < n) check(bs_state === e[k], "fm0 level");
			if (m != `UTAC_MODE_FM0 && k < n) check(bs_state === g[k], "miller level");
			k++;
			repeat (h) @(posedge ref_clk);
		end
		check(k == n, "reply length");
		check(bs_state === 1'h0, "reflection left on");
		repeat (8 * h) @(posedge ref_clk);
		check(t2_window === 1'h1, "turnaround window");
	endtask
	// Preamble plus Query, round settings, then the reply
	task automatic round(input int tari, input logic [1:0] m, input logic x, input int t2);
		logic [15:0] b;
		logic [15:0] mask;
		int e0;
		int e1;
		b = 16'($urandom);
		mask = (tari <= 200) ? 16'hFFFF : 16'h00FF;
		e0 = ends;
		e1 = errs;
		tx_word <= 16'($urandom);
		i_reader.frame(t2, tari, 1'h1, b, (tari <= 200) ? 16 : 8);
		check(((got ^ b) & mask) === 16'h0000, "decoded bits");
		check(rx_preamble === 1'h1 && errs == e1, "preamble sync");
		check(ends == e0 + 1, "command end");
		round_mode <= m;
		round_trext <= x;
		round_load <= 1'h1;
		@(posedge ref_clk);
		round_load <= 1'h0;
		h = (3 * tari + 8) >> 4;
		reply(x, m);
	endtask
	// ********
	// Main sequence and watchdog
	// ********
	initial begin
		int e;
		reset_n = 1'h0;
		round_load = 1'h0;
		round_trext = 1'h0;
		round_mode = 2'h0;
		tx_start = 1'h0;
		tx_word_valid = 1'h0;
		tx_word = 16'h0000;
		void'($urandom(84392));
		repeat (6) @(posedge ref_clk);
		reset_n <= 1'h1;
		@(posedge ref_clk);
		check(bs_state === 1'h0 && tx_busy === 1'h0, "reset state");
		idle_start;
		round(125, 2'h0, 1'h0, 20);
		repeat (36 * h) @(posedge ref_clk);
		idle_start;
		i_reader.frame(0, 125, 1'h0, 16'h00A5, 8);
		check(rx_preamble === 1'h0 && got[7:0] === 8'hA5, "frame-sync");
		round(500, 2'h0, 1'h1, 4 * h);
		round(250, 2'h1, 1'h1, 22 * h);
		round(125 + int'($urandom % 100), 2'h2, 1'h0, 4 * h);
		round(125, 2'h3, 1'h0, 4 * h);
		// Long reference first: the tail of a refused frame can leave the
		// decoder part-way into a false sync, which the long frame flushes
		e = errs;
		i_reader.frame(20, 501, 1'h1, 16'h0000, 0);
		check(errs > e, "long reference accepted");
		e = errs;
		i_reader.frame(10 * h, 124, 1'h1, 16'h0000, 0);
		check(errs > e, "short reference accepted");
		complete_run;
	end
	// Cut a hang short
	initial begin
		#5000000;
		fail_count++;
		complete_run;
	end
endmodule // test_uhf_tag_air_link_codec
`default_nettype wire
